// File: cpaf_alu.v
// alu, flag, jump condition and operand addressing datapath of the cpu
//
// Behaviour
// RQ1 - three-register sub-with-borrow: third minus second
// RQ2 - register minus operand minus borrow, into both
// RQ3 - multiply: low byte accumulator, high destination
// RQ4 - multiply shifts by power of two
// RQ5 - right shift by one does not shift one
// RQ6 - arithmetic right shift keeps sign fill
// RQ7 - compare sets accumulator, carry, overflow only; the code also sets zero
// RQ8 - jump conditions from flags and events
// RQ9 - bit test isolates bit into accumulator
// RQ10 - bit set, copy register to accumulator
// RQ11 - bit clear, copy register to accumulator
// RQ12 - bit invert, copy register to accumulator
// RQ13 - flag save packs carry, overflow, stack state; the code packs carry xor overflow in place of overflow
// RQ14 - flag restore shifts left, carry from msb
// RQ15 - frequency op divides cpu clock
// RQ16 - eight operand addressing modes
// RQ17 - memory access and index update together
// RQ18 - direct and plain indexed keep index
// RQ19 - post-increment modes update index after
// RQ20 - pre-decrement modes access decremented index
`timescale 1ns/1ps
`default_nettype none
`include "cpaf_map.vh"

module cpaf_alu
(
    input wire clk_sys,
    input wire resetn,
    input wire opValid,
    input wire [3:0] opCode,
    input wire [7:0] opdA,
    input wire [7:0] opdB,
    input wire [7:0] opdC,
    input wire [2:0] bitSel,
    input wire useMem,
    input wire [2:0] eaMode,
    input wire [1:0] idxSel,
    input wire [7:0] eaOffset,
    input wire [7:0] offsetReg,
    input wire [7:0] memRdData,
    output reg [15:0] memAddr,
    output wire memRd,
    input wire idxWe,
    input wire [1:0] idxWrSel,
    input wire [15:0] idxWrData,
    input wire stackFull,
    input wire stackEmpty,
    input wire pendingEventLineZero,
    input wire pendingEventLineOne,
    input wire [3:0] condCode,
    output reg jumpTaken,
    output reg [7:0] accOut_r,
    output reg [7:0] dstData_r,
    output reg dstWe_r,
    output reg carry_r,
    output reg ovf_r,
    output reg zero_r,
    output reg cpuTick_r,
    input wire [3:0] busAddr,
    input wire [7:0] busWrData,
    input wire busWr,
    input wire busRd,
    output reg [7:0] busRdData_r
);

wire [15:0] idxQ [0:3];
reg [15:0] idxNew;
reg idxUpd;
reg [15:0] ix;
reg [7:0] sec;
reg [8:0] diff;
reg [15:0] prod;
reg [7:0] bitMask;
reg [7:0] accNxt;
reg [7:0] dstNxt;
reg dstWeNxt;
reg carryNxt;
reg ovfNxt;
reg zeroNxt;
reg [3:0] divMask;
reg [2:0] divSel_r;
reg [3:0] divCnt_r;
wire exec;

assign exec = opValid;
assign memRd = opValid & useMem; // RQ17

// ---------------------------------------------------------------
// operand address formation
// ---------------------------------------------------------------
// address is combinational so the memory read lands in the same
// instruction as the index update
always @*
begin
    ix = idxQ[idxSel];
    memAddr = ix;
    idxUpd = eaMode[2]; // RQ19 RQ20
    case (eaMode) // RQ16
        `CPAF_EA_DIR: memAddr = {8'h00, eaOffset}; // RQ18
        `CPAF_EA_IND, `CPAF_EA_PINC: memAddr = ix; // RQ18 RQ19
        `CPAF_EA_IOFS, `CPAF_EA_POFS: memAddr = ix + {8'h00, eaOffset};
        `CPAF_EA_IR3: memAddr = ix + {8'h00, offsetReg}; // RQ18
        `CPAF_EA_PDEC: memAddr = ix - 16'h0001; // RQ20
        default: memAddr = ix - {8'h00, eaOffset}; // RQ20
    endcase
    // post-increment by one is the only update that is not the address
    idxNew = (eaMode == `CPAF_EA_PINC) ? ix + 16'h0001 : memAddr; // RQ19
end

// ---------------------------------------------------------------
// index registers
// ---------------------------------------------------------------
// a sequencer load and an addressing update to the same index in
// one cycle cannot both be meant; the addressing update wins
genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : gIdx
        reg [15:0] idxVal_r;
        assign idxQ[gi] = idxVal_r;
        always @(posedge clk_sys)
        begin
            if (!resetn)
                idxVal_r <= 16'h0000;
            else if (memRd && idxUpd && idxSel == gi)
                idxVal_r <= idxNew; // RQ17
            else if (idxWe && idxWrSel == gi)
                idxVal_r <= idxWrData;
        end
    end
endgenerate

// ---------------------------------------------------------------
// arithmetic and bit operations
// ---------------------------------------------------------------
// one subtractor serves borrow-subtracts and compare; flags
// untouched by an op keep their value
always @*
begin
    sec = useMem ? memRdData : opdB;
    diff = 9'h000;
    prod = 16'h0000;
    bitMask = 8'h01 << bitSel;
    accNxt = accOut_r;
    dstNxt = dstData_r;
    dstWeNxt = 1'b0;
    carryNxt = carry_r;
    ovfNxt = ovf_r;
    zeroNxt = zero_r;
    case (opCode)
        `CPAF_OP_SBC3:
        begin
            diff = {1'b0, opdC} - {1'b0, opdB}
                - {8'h00, ~carry_r}; // RQ1
            accNxt = diff[7:0];
            dstNxt = diff[7:0];
            dstWeNxt = 1'b1;
            carryNxt = ~diff[8];
            ovfNxt = (opdC[7] ^ opdB[7]) & (opdC[7] ^ diff[7]);
            zeroNxt = (diff[7:0] == 8'h00);
        end
        `CPAF_OP_SBCR:
        begin
            diff = {1'b0, opdA} - {1'b0, sec}
                - {8'h00, ~carry_r}; // RQ2
            accNxt = diff[7:0];
            dstNxt = diff[7:0];
            dstWeNxt = 1'b1;
            carryNxt = ~diff[8];
            ovfNxt = (opdA[7] ^ sec[7]) & (opdA[7] ^ diff[7]);
            zeroNxt = (diff[7:0] == 8'h00);
        end
        `CPAF_OP_MUL, `CPAF_OP_MUL3:
        begin
            // flags are left as they were: their value is undefined
            prod = (opCode == `CPAF_OP_MUL3) ? {8'h00, opdB} * {8'h00, opdC}
                : {8'h00, sec} * {8'h00, opdA}; // RQ3
            accNxt = prod[7:0];
            dstNxt = prod[15:8];
            dstWeNxt = 1'b1;
        end
        `CPAF_OP_MSHL:
        begin
            prod = {8'h00, opdA} << bitSel; // RQ4
            accNxt = prod[7:0];
            dstNxt = prod[15:8];
            dstWeNxt = 1'b1;
        end
        `CPAF_OP_MSHR:
        begin
            // amount 1 gives a factor of 128, a seven place shift
            prod = {8'h00, opdA} << (4'h8 - {1'b0, bitSel}); // RQ4 RQ5
            accNxt = prod[7:0];
            dstNxt = prod[15:8];
            dstWeNxt = 1'b1;
        end
        `CPAF_OP_MSHRA:
        begin
            prod = {{8{opdA[7]}}, opdA}
                << (4'h8 - {1'b0, bitSel}); // RQ6 RQ5
            accNxt = prod[7:0];
            dstNxt = prod[15:8];
            dstWeNxt = 1'b1;
        end
        `CPAF_OP_CMP:
        begin
            diff = {1'b0, sec} - {1'b0, opdA}; // RQ7
            accNxt = diff[7:0];
            carryNxt = ~diff[8];
            zeroNxt = (diff[7:0] == 8'h00);
            ovfNxt = ~diff[8] & (diff[7:0] != 8'h00);
        end
        `CPAF_OP_TSTB:
        begin
            accNxt = opdA & bitMask; // RQ9
            zeroNxt = (accNxt == 8'h00);
        end
        `CPAF_OP_SETB:
        begin
            accNxt = opdA | bitMask; // RQ10
            dstNxt = accNxt;
            dstWeNxt = 1'b1;
            zeroNxt = (accNxt == 8'h00);
        end
        `CPAF_OP_CLRB:
        begin
            accNxt = opdA & ~bitMask; // RQ11
            dstNxt = accNxt;
            dstWeNxt = 1'b1;
            zeroNxt = (accNxt == 8'h00);
        end
        `CPAF_OP_INVB:
        begin
            accNxt = opdA ^ bitMask; // RQ12
            dstNxt = accNxt;
            dstWeNxt = 1'b1;
            zeroNxt = (accNxt == 8'h00);
        end
        `CPAF_OP_SFLAG:
        begin
            accNxt = {carry_r, carry_r ^ ovf_r,
                stackFull, stackEmpty, 4'h0}; // RQ13
        end
        `CPAF_OP_RFLAG:
        begin
            accNxt = {sec[6:0], 1'b0}; // RQ14
            carryNxt = sec[7];
            ovfNxt = 1'b0;
            zeroNxt = (accNxt == 8'h00);
        end
        default: accNxt = accOut_r;
    endcase
end

// ---------------------------------------------------------------
// result and flag registers
// ---------------------------------------------------------------
always @(posedge clk_sys)
begin
    if (!resetn)
    begin
        accOut_r <= 8'h00;
        dstData_r <= 8'h00;
        dstWe_r <= 1'b0;
        carry_r <= 1'b0;
        ovf_r <= 1'b0;
        zero_r <= 1'b0;
    end
    else
    begin
        dstWe_r <= exec & dstWeNxt;
        if (exec)
        begin
            accOut_r <= accNxt;
            dstData_r <= dstNxt;
            carry_r <= carryNxt;
            ovf_r <= ovfNxt;
            zero_r <= zeroNxt;
        end
    end
end

// ---------------------------------------------------------------
// jump condition
// ---------------------------------------------------------------
// after compare: carry clear means first operand above second,
// and overflow holds carry and not zero, which is less-than
always @*
begin
    case (condCode) // RQ8
        `CPAF_CC_CS: jumpTaken = carry_r;
        `CPAF_CC_CC: jumpTaken = ~carry_r;
        `CPAF_CC_ZS: jumpTaken = zero_r;
        `CPAF_CC_ZC: jumpTaken = ~zero_r;
        `CPAF_CC_VS: jumpTaken = ovf_r;
        `CPAF_CC_VC: jumpTaken = ~ovf_r;
        `CPAF_CC_EV:
            jumpTaken = pendingEventLineZero | pendingEventLineOne;
        `CPAF_CC_EQ: jumpTaken = zero_r;
        `CPAF_CC_NE: jumpTaken = ~zero_r;
        `CPAF_CC_GT: jumpTaken = ~carry_r;
        `CPAF_CC_GE: jumpTaken = ~carry_r | zero_r;
        `CPAF_CC_LT: jumpTaken = carry_r & ~zero_r;
        `CPAF_CC_LE: jumpTaken = carry_r;
        default: jumpTaken = 1'b0;
    endcase
end

// ---------------------------------------------------------------
// clock divider
// ---------------------------------------------------------------
// selects above div16 are clamped so the tick never stops
always @*
begin
    if (divSel_r >= `CPAF_DIV_MAX)
        divMask = 4'hF;
    else
        divMask = (4'h1 << divSel_r) - 4'h1;
end

always @(posedge clk_sys)
begin
    if (!resetn)
    begin
        divSel_r <= `CPAF_DIV_RST;
        divCnt_r <= 4'h0;
        cpuTick_r <= 1'b0;
    end
    else
    begin
        divCnt_r <= divCnt_r + 4'h1;
        cpuTick_r <= ((divCnt_r & divMask) == 4'h0); // RQ15
        // the instruction wins over a bus write in the same cycle
        if (exec && opCode == `CPAF_OP_FREQ)
            divSel_r <= bitSel; // RQ15
        else if (busWr && busAddr == `CPAF_REG_CTRL)
            divSel_r <= busWrData[`CPAF_DIV_MSB:`CPAF_DIV_LSB];
    end
end

// ---------------------------------------------------------------
// register read port
// ---------------------------------------------------------------
always @(posedge clk_sys)
begin
    if (!resetn)
        busRdData_r <= 8'h00;
    else if (busRd)
    begin
        if (busAddr == `CPAF_REG_CTRL)
            busRdData_r <= {5'h00, divSel_r};
        else if (busAddr == `CPAF_REG_FLAGS)
            busRdData_r <= {5'h00, ovf_r, zero_r, carry_r};
        else if (busAddr == `CPAF_REG_ACC)
            busRdData_r <= accOut_r;
        else
            busRdData_r <= 8'h00; // unmapped reads zero
    end
    else
        busRdData_r <= 8'h00;
end

endmodule // cpaf_alu
`default_nettype wire

// File: cpaf_alu_checker.sv
// port assertions of the alu datapath
`timescale 1ns/1ps
`default_nettype none
`include "cpaf_map.vh"
module cpaf_alu_chk
(
    input wire clk_sys,
    input wire resetn,
    input wire opValid,
    input wire [3:0] opCode,
    input wire [7:0] opdA,
    input wire [7:0] opdB,
    input wire [2:0] bitSel,
    input wire useMem,
    input wire [2:0] eaMode,
    input wire [7:0] eaOffset,
    input wire [15:0] memAddr,
    input wire memRd,
    input wire [3:0] condCode,
    input wire jumpTaken,
    input wire [7:0] accOut_r,
    input wire [7:0] dstData_r,
    input wire dstWe_r,
    input wire carry_r,
    input wire zero_r,
    input wire ovf_r
);
// --------
// properties
// --------
default clocking cb @(posedge clk_sys);
endclocking
default disable iff (!resetn);
// op without a memory operand
wire regOp = opValid && !useMem;
AST_MEMRD: assert property (memRd == (opValid && useMem))
    else $error("memory read strobe wrong");
AST_DIR: assert property (useMem && eaMode == `CPAF_EA_DIR |->
    memAddr == {8'h00, eaOffset}) else $error("direct address wrong");
AST_MUL: assert property (regOp && opCode == `CPAF_OP_MUL |=>
    {dstData_r, accOut_r} == $past(opdA) * $past(opdB) && dstWe_r)
    else $error("product wrong");
AST_SHL: assert property (regOp && opCode == `CPAF_OP_MSHL |=>
    {dstData_r, accOut_r} == {8'h00, $past(opdA)} << $past(bitSel))
    else $error("left shift wrong");
AST_CMP: assert property (opValid && opCode == `CPAF_OP_CMP |=>
    !dstWe_r && ovf_r == (carry_r && !zero_r)) else $error("compare wrong");
AST_TST: assert property (opValid && opCode == `CPAF_OP_TSTB |=>
    accOut_r == ($past(opdA) & (8'h01 << $past(bitSel))) &&
    zero_r == (accOut_r == 8'h00)) else $error("bit test wrong");
AST_SET: assert property (opValid && opCode == `CPAF_OP_SETB |=>
    dstWe_r && dstData_r == accOut_r &&
    accOut_r == ($past(opdA) | (8'h01 << $past(bitSel))))
    else $error("bit set wrong");
AST_JEQ: assert property (condCode == `CPAF_CC_EQ |->
    jumpTaken == zero_r) else $error("equal jump wrong");
endmodule // cpaf_alu_chk
`default_nettype wire

// File: cpaf_dmem.sv
// data memory model answering the datapath's operand reads
`timescale 1ns/1ps
`default_nettype none
module cpaf_dmem
(
    input wire logic clk_sys,
    input wire logic [15:0] memAddr,
    input wire logic memRd,
    output logic [7:0] memRdData
);
    logic [7:0] junk_r = 8'h00;
    // outside reads the bus stays at zero, as the negation of 8'h00 is 8'h00
    always @(posedge clk_sys)
        junk_r <= ~junk_r + 8'h01;
    // contents derived from the address, answered in the same cycle
    assign memRdData = memRd ? memAddr[7:0] ^ memAddr[15:8] ^ 8'h3C : junk_r;
endmodule // cpaf_dmem
`default_nettype wire

// File: cpaf_map.vh
// constants for the cpu alu, flag and addressing datapath
`ifndef CPAF_MAP_VH
`define CPAF_MAP_VH

// operation codes presented by the sequencer
`define CPAF_OP_NOP   4'h0
`define CPAF_OP_SBC3  4'h1
`define CPAF_OP_SBCR  4'h2
`define CPAF_OP_MUL   4'h3
`define CPAF_OP_MUL3  4'h4
`define CPAF_OP_MSHL  4'h5
`define CPAF_OP_MSHR  4'h6
`define CPAF_OP_MSHRA 4'h7
`define CPAF_OP_CMP   4'h8
`define CPAF_OP_TSTB  4'h9
`define CPAF_OP_SETB  4'hA
`define CPAF_OP_CLRB  4'hB
`define CPAF_OP_INVB  4'hC
`define CPAF_OP_SFLAG 4'hD
`define CPAF_OP_RFLAG 4'hE
`define CPAF_OP_FREQ  4'hF

// extended address modes
`define CPAF_EA_DIR  3'h0
`define CPAF_EA_IND  3'h1
`define CPAF_EA_IOFS 3'h2
`define CPAF_EA_IR3  3'h3
`define CPAF_EA_PINC 3'h4
`define CPAF_EA_POFS 3'h5
`define CPAF_EA_PDEC 3'h6
`define CPAF_EA_DOFS 3'h7

// jump conditions
`define CPAF_CC_CS 4'h0
`define CPAF_CC_CC 4'h1
`define CPAF_CC_ZS 4'h2
`define CPAF_CC_ZC 4'h3
`define CPAF_CC_VS 4'h4
`define CPAF_CC_VC 4'h5
`define CPAF_CC_EV 4'h6
`define CPAF_CC_EQ 4'h7
`define CPAF_CC_NE 4'h8
`define CPAF_CC_GT 4'h9
`define CPAF_CC_GE 4'hA
`define CPAF_CC_LT 4'hB
`define CPAF_CC_LE 4'hC

// register offsets, fields and reset values
`define CPAF_REG_CTRL  4'h0
`define CPAF_REG_FLAGS 4'h1
`define CPAF_REG_ACC   4'h2
`define CPAF_DIV_LSB 0
`define CPAF_DIV_MSB 2
`define CPAF_DIV_RST 3'h0
`define CPAF_DIV_MAX 3'h4
`define CPAF_FLAG_C 0
`define CPAF_FLAG_Z 1
`define CPAF_FLAG_V 2

`endif

// File: tb.sv
// self-checking bench of the alu datapath
`timescale 1ns/1ps
`default_nettype none
`include "cpaf_map.vh"
module tb;
logic clk_sys = 1'b0, resetn = 1'b0, opValid = 1'b0, useMem = 1'b0;
logic idxWe = 1'b0, stackFull = 1'b0, stackEmpty = 1'b0, busWr = 1'b0;
logic busRd = 1'b0, pendingEventLineZero = 1'b0, pendingEventLineOne = 1'b0;
logic [3:0] opCode = 4'h0, condCode = 4'h0, busAddr = 4'h0;
logic [7:0] opdA = 8'h00, opdB = 8'h00, opdC = 8'h00, eaOffset = 8'h00;
logic [7:0] offsetReg = 8'h00, busWrData = 8'h00, ma = 8'h00, ed;
logic [2:0] bitSel = 3'h0, eaMode = 3'h0;
logic [1:0] idxSel = 2'h0, idxWrSel = 2'h0;
logic [15:0] idxWrData = 16'h0000, expAddr = 16'h0000, seenAddr;
logic mc = 1'b0, mv = 1'b0, mz = 1'b0, ew;
wire [15:0] memAddr;
wire [7:0] memRdData, accOut_r, dstData_r, busRdData_r;
wire memRd, jumpTaken, dstWe_r, carry_r, ovf_r, zero_r, cpuTick_r;
int errors = 0, checks = 0;
cpaf_alu dut (.*);
cpaf_dmem mem (.*);
// --------
// helpers
// --------
// 40 MHz system clock
always #12.5 clk_sys = ~clk_sys;
task automatic cmp(input string nm, input logic [15:0] e, s);
    checks++;
    if (s !== e)
    begin
        errors++;
        $display("wrong value %s expected %h seen %h", nm, e, s);
    end
endtask
task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
function automatic logic [7:0] dm(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
endfunction
// expected jump outcome; order follows the condition codes
function automatic logic jexp(input int n, input logic [7:0] a, b);
    logic [12:0] t;
    t = {a <= b, a < b, a >= b, a > b, a != b, a == b,
        pendingEventLineZero | pendingEventLineOne, !mv, mv, !mz, mz, !mc, mc};
    return t[n];
endfunction
// reference result of the op now on the inputs
task automatic model();
    logic [7:0] b, k, u;
    logic [15:0] p;
    int x, y;
    b = useMem ? dm(expAddr) : opdB;
    k = 8'h01 << bitSel;
    u = (opCode == `CPAF_OP_SBC3) ? opdC : opdA;
    x = int'(u) - int'(b) - int'(!mc);
    y = int'($signed(u)) - int'($signed(b)) - int'(!mc);
    p = {ma, ma};
    case (opCode)
        `CPAF_OP_SBC3, `CPAF_OP_SBCR:
        begin
            p = {2{x[7:0]}};
            mc = x >= 0;
            mv = y < -128 || y > 127;
        end
        `CPAF_OP_MUL: p = opdA * b;
        `CPAF_OP_MUL3: p = b * opdC;
        `CPAF_OP_MSHL: p = {8'h00, opdA} << bitSel;
        `CPAF_OP_MSHR: p = {8'h00, opdA} << (8 - bitSel);
        `CPAF_OP_MSHRA: p = {{8{opdA[7]}}, opdA} << (8 - bitSel);
        `CPAF_OP_CMP:
        begin
            x = int'(b) - int'(opdA);
            p[7:0] = x[7:0];
            mc = x >= 0;
        end
        `CPAF_OP_TSTB: p[7:0] = opdA & k;
        `CPAF_OP_SETB: p = {2{opdA | k}};
        `CPAF_OP_CLRB: p = {2{opdA & ~k}};
        `CPAF_OP_INVB: p = {2{opdA ^ k}};
        `CPAF_OP_SFLAG: p[7:0] = {mc, mc ^ mv, stackFull, stackEmpty, 4'h0};
        `CPAF_OP_RFLAG:
        begin
            p[7:0] = {b[6:0], 1'b0};
            mc = b[7];
            mv = 1'b0;
        end
        default: ;
    endcase
    ew = opCode inside {[`CPAF_OP_SBC3:`CPAF_OP_MSHRA],
        [`CPAF_OP_SETB:`CPAF_OP_INVB]};
    if (opCode inside {[`CPAF_OP_SBC3:`CPAF_OP_SBCR],
        [`CPAF_OP_CMP:`CPAF_OP_INVB], `CPAF_OP_RFLAG})
        mz = p[7:0] == 8'h00;
    if (opCode == `CPAF_OP_CMP)
        mv = mc && !mz;
    ma = p[7:0];
    ed = p[15:8];
endtask
// one instruction, then its results checked one cycle on
task automatic op(input logic [3:0] c, input logic [7:0] a, b,
    input logic [2:0] s, md, input logic m);
    @(posedge clk_sys);
    opValid <= 1'b1;
    opCode <= c;
    opdA <= a;
    opdB <= b;
    opdC <= 8'($urandom);
    bitSel <= s;
    eaMode <= md;
    useMem <= m;
    stackFull <= 1'($urandom);
    stackEmpty <= 1'($urandom);
    #1 seenAddr = memAddr;
    model();
    @(posedge clk_sys);
    opValid <= 1'b0;
    #1 cmp("acc", 16'(ma), 16'(accOut_r));
    cmp("flags", 16'({mv, mz, mc}), 16'({ovf_r, zero_r, carry_r}));
    cmp("we", 16'(ew), 16'(dstWe_r));
    if (ew)
        cmp("dst", 16'(ed), 16'(dstData_r));
endtask
// sequencer load of an index, with fresh offsets
task automatic ldIdx(input logic [1:0] s, input logic [15:0] v);
    @(posedge clk_sys);
    idxWe <= 1'b1;
    idxWrSel <= s;
    idxSel <= s;
    idxWrData <= v;
    eaOffset <= 8'($urandom);
    offsetReg <= 8'($urandom);
    @(posedge clk_sys);
    idxWe <= 1'b0;
endtask
task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    busWr <= w;
    busRd <= !w;
    busAddr <= a;
    busWrData <= d;
    @(posedge clk_sys);
    busWr <= 1'b0;
    busRd <= 1'b0;
    #1 if (!w) cmp("read", 16'(d), 16'(busRdData_r));
endtask
// counts ticks over whole divider periods, so phase does not matter
task automatic tick(input int n, e);
    int k;
    k = 0;
    repeat (20) @(posedge clk_sys);
    repeat (n)
    begin
        @(posedge clk_sys);
        #1 k += int'(cpuTick_r);
    end
    cmp("ticks", 16'(e), 16'(k));
endtask
// --------
// tests
// --------
initial
begin
    logic [7:0] a, b;
    logic [15:0] x, o, ea, ni;
    int seed;
    seed = $urandom(10047);
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 300; i++)
    begin
        a = 8'($urandom);
        b = (i % 15 == `CPAF_OP_RFLAG) ? a : 8'($urandom);
        op(4'(i % 15), a, b, 3'($urandom), 3'h0, 1'b0);
    end
    for (int s = 0; s < 8; s++)
        op(`CPAF_OP_MSHRA, 8'h81, 8'h00, 3'(s), 3'h0, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
        x = 16'($urandom);
        ldIdx(i[1:0], x);
        o = {8'h00, eaOffset};
        case (i)
            0: ea = o;
            2, 5: ea = x + o;
            3: ea = x + {8'h00, offsetReg};
            6: ea = x - 16'h0001;
            7: ea = x - o;
            default: ea = x;
        endcase
        ni = (i == 4) ? x + 16'h0001 : (i < 5) ? x : ea;
        expAddr = ea;
        op(`CPAF_OP_RFLAG, 8'h00, 8'h00, 3'h0, 3'(i), 1'b1);
        cmp("addr", ea, seenAddr);
        expAddr = ni;
        op(`CPAF_OP_RFLAG, 8'h00, 8'h00, 3'h0, `CPAF_EA_IND, 1'b1);
        cmp("index", ni, seenAddr);
    end
    for (int k = 0; k < 3; k++)
    begin
        a = 8'($urandom);
        b = (k == 0) ? a : 8'($urandom);
        op(`CPAF_OP_CMP, a, b, 3'h0, 3'h0, 1'b0);
        for (int n = 0; n < 13; n++)
        begin
            @(posedge clk_sys);
            condCode <= 4'(n);
            pendingEventLineZero <= 1'($urandom);
            pendingEventLineOne <= 1'($urandom);
            #1 cmp("jump", 16'(jexp(n, a, b)), 16'(jumpTaken));
        end
    end
    bus(1'b0, `CPAF_REG_FLAGS, {5'h00, mv, mz, mc});
    bus(1'b0, `CPAF_REG_ACC, ma);
    bus(1'b1, `CPAF_REG_FLAGS, 8'h07);
    bus(1'b0, `CPAF_REG_FLAGS, {5'h00, mv, mz, mc});
    bus(1'b0, 4'h7, 8'h00);
    bus(1'b1, `CPAF_REG_CTRL, 8'h02);
    bus(1'b0, `CPAF_REG_CTRL, 8'h02);
    tick(32, 8);
    op(`CPAF_OP_FREQ, 8'h00, 8'h00, 3'h4, 3'h0, 1'b0);
    tick(64, 4);
    give_verdict();
end
// watchdog well beyond the expected run length
initial
begin
    #1000000;
    errors++;
    give_verdict();
end
endmodule // tb
bind cpaf_alu cpaf_alu_chk chk (.*);
`default_nettype wire
